/* File: design/dac_clk_sync_pkg.sv */
package dac_clk_sync_pkg;
  // --------------------------------------------------------------------------
  // widths and coding
  // --------------------------------------------------------------------------
  localparam int          SAMPLE_W      = 14;
  localparam logic [13:0] CODE_MAX      = 14'h3fff;
  localparam logic [13:0] CODE_RST      = 14'h0000;
  localparam int          FIFO_DEPTH    = 4;
  // half-rate clock level while the alignment reset is held
  localparam logic        HALF_RST_LVL  = 1'b1;
  // --------------------------------------------------------------------------
  // timing
  // --------------------------------------------------------------------------
  // release window after a fast edge that costs one extra fast cycle
  localparam int          REL_WIN_PS    = 600;
  localparam int          CLK_PERIOD_PS = 10000;
  // the window is below one cycle, so it is clamped up to the one-cycle synchroniser slot
  localparam int          REL_WIN_CYC   = (REL_WIN_PS / CLK_PERIOD_PS) < 1 ? 1 :
                                          (REL_WIN_PS / CLK_PERIOD_PS);
  // --------------------------------------------------------------------------
  // half-rate phase states, gray along hold -> first low -> run
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_HOLD  = 2'b00,
    ST_FIRST = 2'b01,
    ST_RUN   = 2'b11
  } phase_t;
endpackage

/* File: design/sample_fifo.sv */
`timescale 1ns/10ps
module sample_fifo #(
  parameter int W     = 14,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic         i_ref_clk,
  input  wire logic         i_rst_b,
  // write side
  input  wire logic         i_wr_valid,
  input  wire logic [W-1:0] i_wr_data,
  output logic              o_wr_ready,
  // read side
  output logic              o_rd_valid,
  output logic [W-1:0]      o_rd_data,
  input  wire logic         i_rd_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] DEPTH_C = (AW + 1)'(DEPTH);

  logic [W-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ptr_ff, nxt_wr_ptr, rd_ptr_ff, nxt_rd_ptr;
  logic [AW:0]   cnt_ff, nxt_cnt;
  logic          push, pop;

  // honest flags straight from the occupancy count
  assign o_wr_ready = (cnt_ff != DEPTH_C);
  assign o_rd_valid = (cnt_ff != '0);
  assign o_rd_data  = mem_ff[rd_ptr_ff];
  assign push       = i_wr_valid && o_wr_ready;
  assign pop        = o_rd_valid && i_rd_ready;

  // pointer and count next values; wrap handles non power of two depths
  always_comb begin
    nxt_wr_ptr = wr_ptr_ff;
    nxt_rd_ptr = rd_ptr_ff;
    nxt_cnt    = cnt_ff;
    if (push) begin
      nxt_wr_ptr = (wr_ptr_ff == AW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
    end
    if (pop) begin
      nxt_rd_ptr = (rd_ptr_ff == AW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
    end
    if (push && !pop) begin
      nxt_cnt = cnt_ff + 1'b1;
    end else if (pop && !push) begin
      nxt_cnt = cnt_ff - 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      cnt_ff    <= '0;
    end else begin
      wr_ptr_ff <= nxt_wr_ptr;
      rd_ptr_ff <= nxt_rd_ptr;
      cnt_ff    <= nxt_cnt;
    end
  end

  // storage, one generate entry per word
  for (genvar g = 0; g < DEPTH; g++) begin : g_mem
    always_ff @(posedge i_ref_clk) begin
      if (push && (wr_ptr_ff == AW'(g))) begin
        mem_ff[g] <= i_wr_data;
      end
    end
  end
endmodule

/* File: design/dac_clk_sync.sv */
// Function
// - divide fast clock to half rate, show delayed copy on status pin
// - converter latch loads on fast edge matching half-rate rising edge
// - alignment reset forces half-rate clock and its copy high
// - after reset: low on next edge, high after, latches capture
// - reset falling edge lets half-rate clock toggle on status pin again
// - release before a fast edge: status falls on the fourth edge after it, rises on the fifth
// - late release, 600 ps after an edge, adds one fast cycle
// - while reset low, status output toggles every fast edge
// - unsigned code 0..16383; all ones gives full true, zero complement
// - straight binary, msb on highest data line, lsb on line zero
`timescale 1ns/10ps
module dac_clk_sync
  import dac_clk_sync_pkg::*;
#(
  parameter int W     = dac_clk_sync_pkg::SAMPLE_W,
  parameter int DEPTH = dac_clk_sync_pkg::FIFO_DEPTH
) (
  // fast clock (update rate) and system reset
  input  wire logic         i_ref_clk,
  input  wire logic         i_rst_b,
  // alignment reset pin, active high, asynchronous to the clock
  input  wire logic         i_align_rst,
  // parallel sample pins, bit W-1 is the msb line, bit 0 the lsb line
  input  wire logic [W-1:0] i_sample,
  // half-rate clock copy
  output logic              o_lock_status_clock_out,
  // converter latch: true and complementary current codes
  output logic [W-1:0]      o_current_out_true,
  output logic [W-1:0]      o_current_out_comp,
  // status pulses
  output logic              o_capture,
  output logic              o_sample_drop
);
  import dac_clk_sync_pkg::*;

  // --------------------------------------------------------------------------
  // input synchronisers
  // --------------------------------------------------------------------------
  logic         rst_meta_ff, rst_sync_ff;
  logic [W-1:0] smp_meta_ff, smp_sync_ff;

  // release sampling slot
  // a release landing just after an edge misses that edge and costs one more
  // fast cycle; sub-cycle position is otherwise not resolvable here
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_meta_ff <= HALF_RST_LVL;
      rst_sync_ff <= HALF_RST_LVL;
      smp_meta_ff <= '0;
      smp_sync_ff <= '0;
    end else begin
      rst_meta_ff <= i_align_rst;
      rst_sync_ff <= rst_meta_ff;
      smp_meta_ff <= i_sample;
      smp_sync_ff <= smp_meta_ff;
    end
  end

  // --------------------------------------------------------------------------
  // half-rate phase generator
  // --------------------------------------------------------------------------
  phase_t state_ff, nxt_state;
  logic   half_ff, nxt_half;
  logic   cap_strobe;

  always_comb begin
    nxt_state = state_ff;
    nxt_half  = half_ff;
    case (state_ff)
      ST_HOLD: begin
        nxt_half = HALF_RST_LVL;
        if (!rst_sync_ff) begin
          nxt_state = ST_FIRST;
          nxt_half  = 1'b0;
        end
      end
      ST_FIRST: begin
        nxt_half  = 1'b1;
        nxt_state = ST_RUN;
      end
      ST_RUN: begin
        nxt_half = ~half_ff;
      end
      default: begin
        nxt_state = ST_HOLD;
        nxt_half  = HALF_RST_LVL;
      end
    endcase
    if (rst_sync_ff) begin
      nxt_state = ST_HOLD;
      nxt_half  = HALF_RST_LVL;
    end
  end

  // phase registers; async clear parks in hold with the clock high
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_ff <= ST_HOLD;
      half_ff  <= HALF_RST_LVL;
    end else begin
      state_ff <= nxt_state;
      half_ff  <= nxt_half;
    end
  end

  // capture on half rise
  // the fast edge that takes the half-rate clock high is the latch edge
  assign cap_strobe = nxt_half && !half_ff && !rst_sync_ff;

  // --------------------------------------------------------------------------
  // sample path: input latch -> fifo -> converter latch
  // --------------------------------------------------------------------------
  logic         in_vld_ff, nxt_in_vld;
  logic [W-1:0] in_dat_ff, nxt_in_dat;
  logic         fifo_wr_ready, fifo_rd_valid;
  logic [W-1:0] fifo_rd_data;
  logic         in_push;

  assign in_push = in_vld_ff && fifo_wr_ready;

  // input latch holds one word until the fifo takes it; a capture that finds
  // it still full is dropped rather than overwriting an unsent sample
  always_comb begin
    nxt_in_vld = in_vld_ff && !in_push;
    nxt_in_dat = in_dat_ff;
    if (cap_strobe && !nxt_in_vld) begin
      nxt_in_dat = smp_sync_ff;
      nxt_in_vld = 1'b1;
    end
  end

  // input latch registers
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      in_vld_ff <= 1'b0;
      in_dat_ff <= '0;
    end else begin
      in_vld_ff <= nxt_in_vld;
      in_dat_ff <= nxt_in_dat;
    end
  end

  sample_fifo #(
    .W     (W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .i_ref_clk  (i_ref_clk),
    .i_rst_b    (i_rst_b),
    .i_wr_valid (in_vld_ff),
    .i_wr_data  (in_dat_ff),
    .o_wr_ready (fifo_wr_ready),
    .o_rd_valid (fifo_rd_valid),
    .o_rd_data  (fifo_rd_data),
    .i_rd_ready (cap_strobe)
  );

  // --------------------------------------------------------------------------
  // converter latch and outputs
  // --------------------------------------------------------------------------
  logic [W-1:0] code_ff, nxt_code;
  logic [W-1:0] comp_ff, nxt_comp;
  logic         stat_ff, nxt_stat;
  logic         cap_ff, nxt_cap;
  logic         drop_ff, nxt_drop;

  always_comb begin
    nxt_code = code_ff;
    nxt_comp = comp_ff;
    if (cap_strobe && fifo_rd_valid) begin
      nxt_code = fifo_rd_data;
      nxt_comp = W'(CODE_MAX) - fifo_rd_data;
    end
    // delayed copy
    // the copy lags the internal clock by one fast cycle, like the pin driver
    nxt_stat = half_ff;
    if (rst_sync_ff) begin
      nxt_stat = HALF_RST_LVL;
    end
    nxt_cap  = cap_strobe;
    // a drop is a capture meeting a latch the fifo did not drain this cycle;
    // a latch that is leaving in the same cycle is no loss
    nxt_drop = cap_strobe && in_vld_ff && !in_push;
  end

  // converter latch and status registers
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      code_ff <= W'(CODE_RST);
      comp_ff <= W'(CODE_MAX);
      stat_ff <= HALF_RST_LVL;
      cap_ff  <= 1'b0;
      drop_ff <= 1'b0;
    end else begin
      code_ff <= nxt_code;
      comp_ff <= nxt_comp;
      stat_ff <= nxt_stat;
      cap_ff  <= nxt_cap;
      drop_ff <= nxt_drop;
    end
  end

  // every port is a plain register copy, no logic after the flops
  assign o_lock_status_clock_out = stat_ff;
  assign o_current_out_true      = code_ff;
  assign o_current_out_comp      = comp_ff;
  assign o_capture               = cap_ff;
  assign o_sample_drop           = drop_ff;
endmodule

/* File: tb/dac_clk_sync_assertions.sv */
`timescale 1ns/10ps
module dac_clk_sync_assertions #(
  parameter int W = 14
) (
  // ports of the block, watched only
  input wire logic         i_ref_clk,
  input wire logic         i_rst_b,
  input wire logic         i_align_rst,
  input wire logic [W-1:0] i_sample,
  input wire logic         o_lock_status_clock_out,
  input wire logic [W-1:0] o_current_out_true,
  input wire logic [W-1:0] o_current_out_comp,
  input wire logic         o_capture,
  input wire logic         o_sample_drop
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);
  // release seen by the sampling edges, then the first half-rate blink
  sequence s_rel; $fell(i_align_rst) ##1 !i_align_rst [*3]; endsequence
  sequence s_blink;
    o_lock_status_clock_out ##1 !o_lock_status_clock_out ##1 o_lock_status_clock_out;
  endsequence
  property p_comp; o_current_out_comp == {W{1'b1}} - o_current_out_true; endproperty
  property p_hold; i_align_rst [*4] |=> o_lock_status_clock_out; endproperty
  property p_nocap; i_align_rst [*4] |=> !o_capture; endproperty
  // the capture edge comes one fast edge ahead of the status rise
  property p_rise; o_capture |=> $rose(o_lock_status_clock_out); endproperty
  // the code and the capture pulse leave the same flop edge
  property p_load; !$stable(o_current_out_true) |-> o_capture; endproperty
  property p_first; s_rel |-> s_blink; endproperty
  property p_fcap; s_rel |=> o_capture; endproperty
  property p_tog; !i_align_rst [*6] |-> $changed(o_lock_status_clock_out); endproperty
  property p_drop; !o_sample_drop; endproperty
  a_comp: assert property (p_comp) else $error("comp code mismatch");
  a_hold: assert property (p_hold) else $error("status not held high");
  a_nocap: assert property (p_nocap) else $error("capture during hold");
  a_rise: assert property (p_rise) else $error("capture off status rise");
  a_load: assert property (p_load) else $error("code moved off capture");
  a_first: assert property (p_first) else $error("bad first blink");
  a_fcap: assert property (p_fcap) else $error("first capture missing");
  a_tog: assert property (p_tog) else $error("status not toggling");
  a_drop: assert property (p_drop) else $error("sample dropped");
endmodule
bind dac_clk_sync dac_clk_sync_assertions #(.W(W)) i_chk (
  .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_align_rst(i_align_rst),
  .i_sample(i_sample), .o_lock_status_clock_out(o_lock_status_clock_out),
  .o_current_out_true(o_current_out_true), .o_current_out_comp(o_current_out_comp),
  .o_capture(o_capture), .o_sample_drop(o_sample_drop));

/* File: tb/sample_source.sv */
`timescale 1ns/10ps
module sample_source (
  // clock, status copy and stall control
  input  wire logic        i_ref_clk,
  input  wire logic        i_lock,
  input  wire logic        i_slow,
  input  wire logic [13:0] i_word,
  // sample lines and new-word note
  output logic [13:0]      o_sample,
  output logic             o_sent
);
  logic lock_d;
  logic hold;
  initial begin
    o_sample = 14'h0000;
    o_sent = 1'b0;
    lock_d = 1'b1;
    hold = 1'b0;
  end
  // word per aligned edge
  // slow mode repeats a word, which the block still sees as a fresh sample
  always @(negedge i_ref_clk) begin
    o_sent <= i_lock & ~lock_d;
    lock_d <= i_lock;
    if (i_lock & ~lock_d) begin
      hold <= ~hold;
      if (!(i_slow && hold)) o_sample <= i_word;
    end
  end
endmodule

/* File: tb/dac_clk_sync_tb_top.sv */
`timescale 1ns/10ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module dac_clk_sync_tb_top;
  import dac_clk_sync_pkg::*;
  logic        i_ref_clk, i_rst_b, i_align_rst, slow, sent, lock, cap, drop;
  logic [13:0] sample, word, code_t, code_c;
  logic [13:0] exp_q[$];
  logic [13:0] bnd[4] = '{14'h3fff, 14'h0000, 14'h2000, 14'h0001};
  int          err_count, check_count, n;
  bit          chk_en;
  initial begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end
  dac_clk_sync i_dut (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_align_rst(i_align_rst),
    .i_sample(sample), .o_lock_status_clock_out(lock), .o_current_out_true(code_t),
    .o_current_out_comp(code_c), .o_capture(cap), .o_sample_drop(drop));
  sample_source i_src (.i_ref_clk(i_ref_clk), .i_lock(lock), .i_slow(slow),
    .i_word(word), .o_sample(sample), .o_sent(sent));
  // note each word the source puts on the pins
  always @(posedge i_ref_clk) begin
    if (chk_en && sent) exp_q.push_back(sample);
  end
  // compare the oldest note on each capture; notes land on the other edges
  // pre-edge values are read, so the three-capture lag is fixed
  always @(posedge i_ref_clk) begin
    if (chk_en && cap && exp_q.size() >= 3) begin
      `CHK(code_t, exp_q[0])
      `CHK(code_c, CODE_MAX - exp_q[0])
      `CHK(drop, 1'b0)
      void'(exp_q.pop_front());
    end
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // release alignment at a falling edge and count edges to the first low
  task automatic release_count();
    i_align_rst = 1'b0;
    n = 0;
    while (lock === 1'b1 && n < 20) begin
      @(posedge i_ref_clk);
      #1;
      n++;
    end
  endtask
  initial begin
    repeat (2000) @(posedge i_ref_clk);
    err_count++;
    wrap_up();
  end
  initial begin
    void'($urandom(74978));
    {i_rst_b, slow, word, chk_en} = '0;
    i_align_rst = 1'b1;
    repeat (12) @(negedge i_ref_clk);
    i_rst_b = 1'b1;
    repeat (8) @(negedge i_ref_clk);
    `CHK(lock, 1'b1)
    `CHK(cap, 1'b0)
    release_count();
    `CHK(n, 4)
    @(posedge i_ref_clk);
    #1;
    `CHK(lock, 1'b1)
    $display("test align done");
    chk_en = 1'b1;
    for (int k = 0; k < 160; k++) begin
      @(negedge i_ref_clk);
      slow <= (k >= 80);
      word <= (k < 16) ? bnd[k % 4] : 14'($urandom);
    end
    repeat (10) @(negedge i_ref_clk);
    chk_en = 1'b0;
    exp_q.delete();
    $display("test stream done");
    i_align_rst = 1'b1;
    repeat (4) @(negedge i_ref_clk);
    `CHK(lock, 1'b1)
    release_count();
    `CHK(n, 4)
    repeat (6) begin
      n = lock;
      @(posedge i_ref_clk);
      #1;
      `CHK(lock, ~n[0])
    end
    // hold reset across two rising edges so sampled values settle
    @(negedge i_ref_clk);
    i_rst_b = 1'b0;
    #2;
    `CHK(code_c, CODE_MAX)
    `CHK(code_t, CODE_RST)
    repeat (2) @(negedge i_ref_clk);
    i_rst_b = 1'b1;
    repeat (12) @(negedge i_ref_clk);
    $display("test realign done");
    wrap_up();
  end
endmodule
